// ==== hw/acg_guard.sv ====
// module: converter start/sample/convert control with reconfiguration guard
//
// Behaviour
// (RQ1) Changing the non-overlap bit during a conversion hangs the converter until device reset.
// (RQ2) Writing the soft reset during a conversion likewise hangs it until device reset.
// (RQ3) Software first sets every slot's trigger source select to 0.
// (RQ4) Software then clears both interrupt start select registers to 0.
// (RQ5) Software then polls the pending start flags until all read zero.
// (RQ6) Software then waits out any running conversion, acquisition plus 13 converter clocks.
// (RQ7) A converter clock is 1 system clock without divide-by-two, 2 with it, 4 with both.
// (RQ8) Only then does software change the non-overlap bit or write the soft reset.
// (RQ9) A trigger source select of 0 means the slot starts only from software; the code still starts such a slot from int_pulse when its isel is 1 or 2.
// (RQ10) Software runs offset self calibration after setup and again as temperature drifts.
// (RQ11) With non-overlap set, sampling starts only once the running conversion is done.
// (RQ12) A conversion takes 13 clocks after sampling, presents on the 14th, latches on the 15th.
// (RQ13) A readable busy indication shows whether any conversion is in progress.
`timescale 1ns/1ps
`default_nettype none
module acg_guard
  import acg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire acg_bus_t bus_req,
  input wire logic [NTRIG-1:0] hw_trig,
  input wire logic [1:0] int_pulse,
  input wire logic [RESW-1:0] adc_data,
  output logic [DW-1:0] rd_data,
  output logic conv_busy,
  output logic conv_hung,
  output logic sampling,
  output logic converting
);
  logic [DW-1:0] slot_ctl_reg [NSLOT];
  logic [RESW-1:0] result_reg [NSLOT];
  logic [2*NSLOT-1:0] isel_reg;
  logic [DW-1:0] ctl2_reg;
  logic [NSLOT-1:0] flags_reg, flags_set, flags_clr;
  logic hung_reg, busy_reg, samp_reg, conv_reg;
  logic [CNTW-1:0] samp_cnt_reg, conv_cnt_reg;
  logic [3:0] samp_slot_reg, conv_slot_reg, pick;
  logic [RESW-1:0] present_reg;
  logic [DW-1:0] rd_data_reg;
  logic tick, wr_misc, wr_slot, soft_rst, nonovl_chg, busy_now;
  logic samp_start, samp_done, handoff, res_latch, all_sw;

  // ==========================================================
  // bus decode
  assign wr_misc = bus_req.wr && (bus_req.addr[5:4] == GRP_MISC);
  assign wr_slot = bus_req.wr && (bus_req.addr[5:4] == GRP_SLOT);
  assign soft_rst = wr_misc && (bus_req.addr[3:0] == REG_CTL1)
                    && bus_req.wdata[CTL1_RESET_BIT];
  assign nonovl_chg = wr_misc && (bus_req.addr[3:0] == REG_CTL2)
                      && (bus_req.wdata[CTL2_NONOVL_BIT]
                          != ctl2_reg[CTL2_NONOVL_BIT]);
  assign busy_now = samp_reg || conv_reg;

  acg_clkdiv u_clkdiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .div2_en(ctl2_reg[CTL2_DIV2_BIT]),
    .div4_en(ctl2_reg[CTL2_DIV4_BIT]),
    .tick(tick)
  );

  // ==========================================================
  // configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl2_reg <= CTL2_RST;
      isel_reg <= '0;
    end else if (wr_misc) begin
      if (bus_req.addr[3:0] == REG_CTL2) ctl2_reg <= bus_req.wdata;
      if (bus_req.addr[3:0] == REG_ISEL1) isel_reg[DW-1:0] <= bus_req.wdata;
      if (bus_req.addr[3:0] == REG_ISEL2) isel_reg[2*DW-1:DW] <= bus_req.wdata;
    end
  end

  // slot controls: trigger source and acquisition window
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NSLOT; i++) slot_ctl_reg[i] <= '0;
    end else if (wr_slot) begin
      slot_ctl_reg[bus_req.addr[3:0]] <= bus_req.wdata;
    end
  end

  // ==========================================================
  // hazard: reconfiguring mid-conversion locks the converter until device reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hung_reg <= 1'b0;
    end else if (busy_now && (nonovl_chg || soft_rst)) begin
      hung_reg <= 1'b1; // [RQ1] [RQ2]
    end
  end

  // ==========================================================
  // pending start flags, one per slot
  generate
    for (genvar g = 0; g < NSLOT; g++) begin : g_slot
      logic [TRGW-1:0] sel;
      logic [SELW-1:0] isel;
      assign sel = slot_ctl_reg[g][TRG_LSB +: TRGW];
      assign isel = isel_reg[SELW*g +: SELW];
      // software-only slots ignore every hw_trig line, but int_pulse still starts them through their isel
      assign flags_set[g] =
          (wr_misc && bus_req.addr[3:0] == REG_FORCE && bus_req.wdata[g])
          || (sel != TRG_SOFTWARE && hw_trig[sel]) // [RQ9]
          || (isel == ISEL_INT1 && int_pulse[0])
          || (isel == ISEL_INT2 && int_pulse[1]);
      assign flags_clr[g] = soft_rst || (samp_start && pick == 4'(g));
    end
  endgenerate

  // set wins over clear so a trigger in the start cycle is not lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~flags_clr) | flags_set;
    end
  end

  // lowest pending slot first
  always_comb begin
    pick = 4'h0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (flags_reg[i]) pick = 4'(i);
    end
  end

  // ==========================================================
  // sample stage
  assign samp_start = !hung_reg && !samp_reg && (|flags_reg) && !soft_rst
                      && !(ctl2_reg[CTL2_NONOVL_BIT] && conv_reg); // [RQ11]
  assign samp_done = samp_reg && tick && (samp_cnt_reg >=
      CNTW'(slot_ctl_reg[samp_slot_reg][ACQ_LSB +: ACQW]));
  assign res_latch = conv_reg && tick && (conv_cnt_reg == LATCH_CLK);
  // overlap mode holds a finished sample until the converter is free
  assign handoff = samp_done && (!conv_reg || res_latch);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samp_reg <= 1'b0;
      samp_cnt_reg <= '0;
      samp_slot_reg <= 4'h0;
    end else if (soft_rst) begin
      samp_reg <= 1'b0;
    end else if (samp_start) begin
      samp_reg <= 1'b1;
      samp_cnt_reg <= '0;
      samp_slot_reg <= pick;
    end else if (handoff) begin
      samp_reg <= 1'b0;
    end else if (samp_reg && tick && !samp_done) begin
      samp_cnt_reg <= samp_cnt_reg + 6'h01;
    end
  end

  // ==========================================================
  // convert stage: 13 clocks, present on 14th, latch on 15th
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_reg <= 1'b0;
      conv_cnt_reg <= '0;
      conv_slot_reg <= 4'h0;
    end else if (soft_rst) begin
      conv_reg <= 1'b0;
    end else if (handoff) begin
      conv_reg <= 1'b1;
      conv_cnt_reg <= '0;
      conv_slot_reg <= samp_slot_reg;
    end else if (res_latch) begin
      conv_reg <= 1'b0; // [RQ12]
    end else if (conv_reg && tick) begin
      conv_cnt_reg <= conv_cnt_reg + 6'h01;
    end
  end

  // result handed to the bus side, then latched a clock later
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      present_reg <= '0;
      for (int i = 0; i < NSLOT; i++) result_reg[i] <= '0;
    end else begin
      if (conv_reg && tick && conv_cnt_reg == PRESENT_CLK) begin
        present_reg <= adc_data; // [RQ12]
      end
      if (res_latch) result_reg[conv_slot_reg] <= present_reg; // [RQ12]
    end
  end

  // ==========================================================
  // status outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_now; // [RQ13]
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= '0;
      if (bus_req.rd) begin
        case (bus_req.addr[5:4])
          GRP_SLOT: rd_data_reg <= slot_ctl_reg[bus_req.addr[3:0]];
          GRP_RES: rd_data_reg <= DW'(result_reg[bus_req.addr[3:0]]);
          GRP_MISC: begin
            case (bus_req.addr[3:0])
              REG_CTL2: rd_data_reg <= ctl2_reg;
              REG_ISEL1: rd_data_reg <= isel_reg[DW-1:0];
              REG_ISEL2: rd_data_reg <= isel_reg[2*DW-1:DW];
              REG_FLAGS: rd_data_reg <= flags_reg;
              REG_STATUS: begin
                rd_data_reg[ST_BUSY_BIT] <= busy_reg; // [RQ13]
                rd_data_reg[ST_HUNG_BIT] <= hung_reg;
                rd_data_reg[ST_SAMP_BIT] <= samp_reg;
                rd_data_reg[ST_CONV_BIT] <= conv_reg;
              end
              default: rd_data_reg <= '0;
            endcase
          end
          default: rd_data_reg <= '0;
        endcase
      end
    end
  end

  assign rd_data = rd_data_reg;
  assign conv_busy = busy_reg;
  assign conv_hung = hung_reg;
  assign sampling = samp_reg;
  assign converting = conv_reg;

  // ==========================================================
  // checks
  // helper for the latch check: system clocks since handoff, and whether
  // the divider stayed at one; a long repetition would slow the tools
  logic [CNTW-1:0] conv_len_reg;
  logic conv_div1_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_len_reg <= '0;
      conv_div1_reg <= 1'b0;
    end else if (soft_rst) begin
      conv_div1_reg <= 1'b0;
    end else if (handoff) begin
      conv_len_reg <= '0;
      conv_div1_reg <= !ctl2_reg[CTL2_DIV2_BIT];
    end else if (conv_reg) begin
      conv_len_reg <= conv_len_reg + 6'h01;
      if (ctl2_reg[CTL2_DIV2_BIT]) conv_div1_reg <= 1'b0;
    end
  end

  always_comb begin
    all_sw = (isel_reg == '0);
    for (int i = 0; i < NSLOT; i++) begin
      if (slot_ctl_reg[i][TRG_LSB +: TRGW] != TRG_SOFTWARE) all_sw = 1'b0;
    end
  end

  a_hung_nonovl: assert property (@(posedge sys_clk) disable iff (rst) // [RQ1]
    busy_now && nonovl_chg |=> conv_hung [*8])
    else $error("non-overlap change mid-conversion did not hang");
  a_hung_reset: assert property (@(posedge sys_clk) disable iff (rst) // [RQ2]
    busy_now && soft_rst |=> conv_hung && !sampling && !converting)
    else $error("soft reset mid-conversion did not hang");
  a_hung_blocks: assert property (@(posedge sys_clk) disable iff (rst) // [RQ1]
    conv_hung && !sampling |=> !sampling)
    else $error("sampling started while hung");
  a_tick_rate: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
    ctl2_reg[CTL2_DIV2_BIT] && !ctl2_reg[CTL2_DIV4_BIT] && tick
    && !wr_misc ##1 !wr_misc |-> !tick ##1 tick)
    else $error("divide-by-two converter clock wrong");
  a_soft_only: assert property (@(posedge sys_clk) disable iff (rst) // [RQ9]
    all_sw && !wr_misc |=> (flags_reg & ~$past(flags_reg)) == '0)
    else $error("software-only slot started by hardware");
  a_nonovl_wait: assert property (@(posedge sys_clk) disable iff (rst) // [RQ11]
    ctl2_reg[CTL2_NONOVL_BIT] && $rose(sampling) |-> !$past(converting))
    else $error("sampling overlapped a conversion");
  a_latch_time: assert property (@(posedge sys_clk) disable iff (rst) // [RQ12]
    $fell(converting) && conv_div1_reg
    |-> $past(conv_len_reg) == LATCH_CLK)
    else $error("conversion length not 15 converter clocks");
  a_busy_flag: assert property (@(posedge sys_clk) disable iff (rst) // [RQ13]
    $rose(sampling) |=> conv_busy [*2])
    else $error("busy indication missing during conversion");
endmodule : acg_guard
`default_nettype wire

// ==== hw/acg_pkg.sv ====
// package: register map, field layout and timing of the converter guard
package acg_pkg;
  // ==========================================================
  // sizes
  localparam int NSLOT = 16;
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int RESW = 12;
  localparam int ACQW = 6;
  localparam int TRGW = 5;
  localparam int NTRIG = 32;
  localparam int SELW = 2;
  localparam int CNTW = 6;
  // ==========================================================
  // register indices (one data word each)
  localparam logic [1:0] GRP_SLOT = 2'h0;
  localparam logic [1:0] GRP_MISC = 2'h1;
  localparam logic [1:0] GRP_RES = 2'h2;
  localparam logic [3:0] REG_CTL1 = 4'h0;
  localparam logic [3:0] REG_CTL2 = 4'h1;
  localparam logic [3:0] REG_ISEL1 = 4'h2;
  localparam logic [3:0] REG_ISEL2 = 4'h3;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_FORCE = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  // ==========================================================
  // field positions
  localparam int ACQ_LSB = 0;
  localparam int TRG_LSB = 6;
  localparam int CTL1_RESET_BIT = 14;
  localparam int CTL2_NONOVL_BIT = 1;
  localparam int CTL2_DIV2_BIT = 2;
  localparam int CTL2_DIV4_BIT = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_HUNG_BIT = 1;
  localparam int ST_SAMP_BIT = 2;
  localparam int ST_CONV_BIT = 3;
  // ==========================================================
  // reset values and encodings
  localparam logic [DW-1:0] CTL2_RST = 16'h0000;
  localparam logic [TRGW-1:0] TRG_SOFTWARE = 5'h00;
  localparam logic [SELW-1:0] ISEL_NONE = 2'h0;
  localparam logic [SELW-1:0] ISEL_INT1 = 2'h1;
  localparam logic [SELW-1:0] ISEL_INT2 = 2'h2;
  // ==========================================================
  // converter clock timing: result steps in converter clocks, divide-by-four phase in system clocks
  localparam logic [CNTW-1:0] PRESENT_CLK = 6'h0D;
  localparam logic [CNTW-1:0] LATCH_CLK = 6'h0E;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // ==========================================================
  // register bus request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } acg_bus_t;
endpackage : acg_pkg

// ==== hw/acg_clkdiv.sv ====
// module: converter clock enable derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module acg_clkdiv
  import acg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic div2_en,
  input wire logic div4_en,
  output logic tick
);
  logic [1:0] div_cnt_reg;

  // ==========================================================
  // free running phase counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= 2'h0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  // one converter clock per 1, 2 or 4 system clocks
  always_comb begin
    if (!div2_en) begin
      tick = 1'b1; // [RQ7]
    end else if (div4_en) begin
      tick = (div_cnt_reg == DIV4_LAST); // [RQ7]
    end else begin
      tick = div_cnt_reg[0]; // [RQ7]
    end
  end
endmodule : acg_clkdiv
`default_nettype wire

// ==== dv/acg_tb.sv ====
// testbench: directed port-level checks of the converter guard
`timescale 1ns/1ps
`default_nettype none
module testbench
  import acg_pkg::*;
;
  // ==========================================================
  // setup
  localparam logic [AW-1:0] A_CTL1 = {GRP_MISC, REG_CTL1};
  localparam logic [AW-1:0] A_CTL2 = {GRP_MISC, REG_CTL2};
  localparam logic [AW-1:0] A_ISEL1 = {GRP_MISC, REG_ISEL1};
  localparam logic [AW-1:0] A_ISEL2 = {GRP_MISC, REG_ISEL2};
  localparam logic [AW-1:0] A_FLAGS = {GRP_MISC, REG_FLAGS};
  localparam logic [AW-1:0] A_FORCE = {GRP_MISC, REG_FORCE};
  localparam logic [AW-1:0] A_STAT = {GRP_MISC, REG_STATUS};
  localparam logic [AW-1:0] A_RES0 = {GRP_RES, 4'h0};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  acg_bus_t bus_req = '0;
  logic [NTRIG-1:0] hw_trig = '0;
  logic [1:0] int_pulse = 2'h0;
  logic [RESW-1:0] adc_data = 12'h000;
  logic [DW-1:0] rd_data;
  logic conv_busy;
  logic conv_hung;
  logic sampling;
  logic converting;
  int bad_count = 0;
  int tests_run = 0;
  // free-running 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  acg_guard DUT (
    .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .hw_trig(hw_trig),
    .int_pulse(int_pulse), .adc_data(adc_data), .rd_data(rd_data),
    .conv_busy(conv_busy), .conv_hung(conv_hung), .sampling(sampling),
    .converting(converting)
  );
  // ==========================================================
  // bus, wait and compare tasks
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // a bound that runs out ends the run as a failure
  task automatic timeout();
    chk(16'h0000, 16'hFFFF);
    stop_test();
  endtask : timeout
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd
  task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic [DW-1:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdchk
  task automatic wait_idle();
    for (int i = 0; i < 600; i++) begin
      @(posedge sys_clk);
      #1;
      if (!sampling && !converting && conv_busy === 1'b0) return;
    end
    timeout();
  endtask : wait_idle
  task automatic wait_conv();
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      #1;
      if (converting === 1'b1) return;
    end
    timeout();
  endtask : wait_conv
  task automatic see_samp(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (sampling === 1'b1) seen = 1'b1;
    end
  endtask : see_samp
  task automatic do_reset();
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset
  // ==========================================================
  // scenarios
  task automatic t_reset();
    #1;
    chk({12'h0, conv_busy, conv_hung, sampling, converting}, 16'h0);
    rdchk(A_STAT, 16'h0000);
    rdchk(A_CTL2, CTL2_RST);
    rdchk(6'h3F, 16'h0000);
    wr(A_FLAGS, 16'hFFFF);
    rdchk(A_FLAGS, 16'h0000);
    wr(6'h05, 16'h0145);
    rdchk(6'h05, 16'h0145);
    wr(A_CTL1, 16'h4000);
    rdchk(A_CTL1, 16'h0000);
    chk({15'h0, conv_hung}, 16'h0);
  endtask : t_reset
  // converting spans 15 converter clocks at each divider ratio
  task automatic t_timing(input logic [DW-1:0] c2, input int r,
                          input logic [RESW-1:0] smp);
    int n;
    n = 0;
    wr(A_CTL2, c2);
    wr(6'h00, 16'h0002);
    adc_data <= smp;
    wr(A_FORCE, 16'h0001);
    wait_conv();
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (converting === 1'b1 && n < 500);
    chk(16'(n), 16'(15 * r));
    rdchk(A_RES0, {4'h0, smp});
    wait_idle();
    rdchk(A_STAT, 16'h0000);
  endtask : t_timing
  task automatic t_status();
    wr(A_FORCE, 16'h0001);
    wait_conv();
    rdchk(A_STAT, 16'h0009);
    wait_idle();
  endtask : t_status
  task automatic t_start(input logic [AW-1:0] a, input logic [DW-1:0] d,
                         input logic kind, input int idx, input logic e);
    logic seen;
    wr(a, d);
    @(posedge sys_clk);
    if (kind) int_pulse[idx] <= 1'b1;
    else hw_trig[idx] <= 1'b1;
    @(posedge sys_clk);
    hw_trig <= '0;
    int_pulse <= 2'h0;
    see_samp(10, seen);
    chk({15'h0, seen}, {15'h0, e});
    wait_idle();
  endtask : t_start
  // two slots at once; the second waits in the pending flags
  task automatic t_overlap(input logic [DW-1:0] c2, input logic e);
    int ovl;
    ovl = 0;
    wr(A_CTL2, c2);
    wr(6'h00, 16'h0003);
    wr(6'h01, 16'h0003);
    wr(A_FORCE, 16'h0003);
    rdchk(A_FLAGS, 16'h0002);
    repeat (120) begin
      @(posedge sys_clk);
      #1;
      if (sampling === 1'b1 && converting === 1'b1) ovl++;
    end
    chk({15'h0, ovl != 0}, {15'h0, e});
    wait_idle();
    rdchk(A_FLAGS, 16'h0000);
    chk({15'h0, conv_hung}, 16'h0);
  endtask : t_overlap
  task automatic t_hazard(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic seen;
    logic [DW-1:0] v;
    wr(A_FORCE, 16'h0001);
    wait_conv();
    wr(a, d);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({15'h0, conv_hung}, 16'h0001);
    wr(A_FORCE, 16'h0001);
    see_samp(40, seen);
    chk({15'h0, seen}, 16'h0000);
    rd(A_STAT, v);
    chk({15'h0, v[ST_HUNG_BIT]}, 16'h0001);
    @(posedge sys_clk);
    do_reset();
    #1;
    chk({15'h0, conv_hung}, 16'h0000);
  endtask : t_hazard
  // full safe sequence under divide-by-four, then reconfigure
  task automatic t_safe();
    logic seen;
    logic [DW-1:0] v;
    wr(A_CTL2, 16'h000C);
    wr(6'h03, 16'h0140);
    wr(A_ISEL1, 16'h0040);
    @(posedge sys_clk);
    hw_trig[5] <= 1'b1;
    @(posedge sys_clk);
    hw_trig <= '0;
    for (int i = 0; i < NSLOT; i++) wr(6'(i), 16'h0000);
    wr(A_ISEL1, 16'h0000);
    wr(A_ISEL2, 16'h0000);
    v = 16'hFFFF;
    for (int i = 0; i < 100 && v !== 16'h0; i++) rd(A_FLAGS, v);
    chk(v, 16'h0000);
    v = 16'hFFFF;
    for (int i = 0; i < 200 && v[ST_BUSY_BIT] !== 1'b0; i++) rd(A_STAT, v);
    chk(v, 16'h0000);
    wr(A_CTL2, 16'h000E);
    wr(A_CTL1, 16'h4000);
    #1;
    chk({15'h0, conv_hung}, 16'h0000);
    // software runs its offset trim here; the block only converts
    wr(A_FORCE, 16'h0001);
    see_samp(20, seen);
    chk({15'h0, seen}, 16'h0001);
    wait_idle();
  endtask : t_safe
  // ==========================================================
  // main sequence
  initial begin
    do_reset();
    t_reset();
    t_timing(16'h0000, 1, 12'hA5C);
    t_timing(16'h0008, 1, 12'h3C1);
    t_timing(16'h0004, 2, 12'hFFF);
    t_timing(16'h000C, 4, 12'h001);
    t_status();
    t_start(6'h04, 16'h01C0, 1'b0, 7, 1'b1);
    t_start(6'h04, 16'h0000, 1'b0, 7, 1'b0);
    t_start(A_ISEL1, 16'h0001, 1'b1, 0, 1'b1);
    t_start(A_ISEL2, 16'h0020, 1'b1, 1, 1'b1);
    t_start(A_ISEL2, 16'h0000, 1'b1, 1, 1'b0);
    t_start(A_ISEL1, 16'h0000, 1'b1, 0, 1'b0);
    t_overlap(16'h0002, 1'b0);
    t_overlap(16'h0000, 1'b1);
    t_hazard(A_CTL2, 16'h0002);
    t_hazard(A_CTL1, 16'h4000);
    t_safe();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
